/* File: core/qbs_sdram_core.sv */
// Quad-bank synchronous DRAM core with an APB mode and status port.
`timescale 1ns/1ps
module qbs_sdram_core #(
  parameter int ROW_W = qbs_pkg::QBS_ROW_W,
  parameter int COL_W = qbs_pkg::QBS_COL_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Command pins.
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [qbs_pkg::QBS_BANK_W-1:0] bank_select_lines,
  input wire logic [ROW_W-1:0] row_col_addr_lines,
  input wire logic [qbs_pkg::QBS_LANES-1:0] byte_lane_masks,
  // Data pins, split into in, out and active-low enable per lane.
  input wire logic [qbs_pkg::QBS_DATA_W-1:0] data_bus_lines_in,
  output logic [qbs_pkg::QBS_DATA_W-1:0] data_bus_lines_out,
  output logic [qbs_pkg::QBS_LANES-1:0] data_bus_lines_oe_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import qbs_pkg::*;

  localparam int AW = QBS_BANK_W + ROW_W + COL_W;
  localparam int DEPTH = 1 << AW;

  typedef struct packed {
    qbs_burst_t st;
    logic [3:0] open;
    logic [3:0][ROW_W-1:0] row;
    logic [1:0] bank;
    logic [COL_W-1:0] start;
    logic [COL_W-1:0] idx;
    logic [COL_W-1:0] blen_m1;
    logic ap;
    logic [1:0] pipe_v;
    logic [1:0][AW-1:0] pipe_a;
    logic [3:0] mask_d1;
    logic dq_v;
    logic [31:0] dq_q;
    logic [3:0] dq_oe_n;
    logic [2:0] bl;
    logic ilv;
    logic cl3;
    logic sw;
    logic err;
    logic pd;
    logic [QBS_REFCNT_W-1:0] refcnt;
    logic [31:0] prdata;
    logic pslverr;
  } qbs_state_t;

  localparam qbs_state_t RST_S = '{
    st: QBS_ST_IDLE, dq_oe_n: 4'hf, bl: QBS_BL_RST, ilv: QBS_ILV_RST,
    cl3: QBS_CL3_RST, sw: QBS_SW_RST, default: '0};

  qbs_state_t s_r, s_nxt;
  logic [2:0] cmd;
  logic [AW-1:0] out_a;
  logic out_v;
  logic [31:0] rd_data;
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [3:0] wr_lane;
  logic rd_go;
  logic wr_go;
  logic fin_ap;

  // Burst length minus one; a write in single-write mode moves one word.
  function automatic logic [COL_W-1:0] blen_of(input logic [2:0] bl,
                                               input logic single);
    logic [COL_W-1:0] r;
    r = '0;
    if (!single) begin
      case (bl)
        QBS_BL_2: r = COL_W'(1);
        QBS_BL_4: r = COL_W'(3);
        QBS_BL_8: r = COL_W'(7);
        QBS_BL_PAGE: r = '1;
        default: r = '0;
      endcase
    end
    return r;
  endfunction

  // Column of word idx: only the bits inside the burst window move.
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                 input logic [COL_W-1:0] idx,
                                                 input logic [COL_W-1:0] m1,
                                                 input logic ilv);
    logic [COL_W-1:0] low;
    low = ilv ? (start ^ idx) : COL_W'(start + idx);
    return (start & ~m1) | (low & m1);
  endfunction

  // A deselected chip sees a no-operation.
  assign cmd = cs_n ? QBS_CMD_NOP : {ras_n, cas_n, we_n};
  // Read stage chosen by latency: two or three edges after the access.
  assign out_v = s_r.cl3 ? s_r.pipe_v[1] : s_r.pipe_v[0];
  assign out_a = s_r.cl3 ? s_r.pipe_a[1] : s_r.pipe_a[0];

  // Byte-lane storage; no reset, contents are undefined at power-up.
  for (genvar g = 0; g < QBS_LANES; g++) begin : g_lane
    logic [7:0] mem [0:DEPTH-1];
    always_ff @(posedge clk) begin
      if (wr_en && wr_lane[g]) begin
        mem[wr_addr] <= data_bus_lines_in[8*g +: 8];
      end
    end
    assign rd_data[8*g +: 8] = mem[out_a];
  end

  // The array is read combinationally from the pipeline address; the registered data
  // stage after it keeps the read latency exact at either latency setting.

  // Next state of the whole core: pins, burst engine and APB.
  always_comb begin
    logic acc_go;
    logic acc_rd;
    logic [1:0] acc_bank;
    logic [COL_W-1:0] acc_col;
    logic [COL_W-1:0] m1;
    logic [31:0] stat;
    acc_go = 1'b0;
    acc_rd = 1'b0;
    acc_bank = '0;
    acc_col = '0;
    m1 = '0;
    stat = '0;
    s_nxt = s_r;
    wr_en = 1'b0;
    wr_addr = '0;
    wr_lane = '0;
    rd_go = 1'b0;
    wr_go = 1'b0;
    fin_ap = 1'b0;

    // APB writes go first so that a hardware set below wins the clear.
    if (psel && penable && pwrite) begin
      if (paddr == QBS_MODE_OFS) begin
        s_nxt.bl = pwdata[QBS_BL_LSB +: 3];
        s_nxt.ilv = pwdata[QBS_ILV_BIT];
        s_nxt.cl3 = pwdata[QBS_CL3_BIT];
        s_nxt.sw = pwdata[QBS_SW_BIT];
      end
      if (paddr == QBS_STATUS_OFS && pwdata[QBS_ERR_BIT]) begin
        s_nxt.err = 1'b0;
      end
    end

    // With clock enable low the command and data pins are ignored: the burst engine sleeps, APB still runs.
    if (cke) begin
      s_nxt.mask_d1 = byte_lane_masks;
      s_nxt.pipe_v = {s_r.pipe_v[0], 1'b0};
      s_nxt.pipe_a[1] = s_r.pipe_a[0];
      s_nxt.dq_v = out_v;
      s_nxt.dq_q = rd_data;
      // Read masks act two edges ahead of the sampling edge.
      s_nxt.dq_oe_n = {4{~out_v}} | s_r.mask_d1;

      // A running burst fetches its next column itself.
      if (s_r.st != QBS_ST_IDLE) begin
        acc_go = 1'b1;
        acc_rd = (s_r.st == QBS_ST_READ);
        acc_bank = s_r.bank;
        acc_col = burst_col(s_r.start, s_r.idx, s_r.blen_m1, s_r.ilv);
        if (s_r.idx == s_r.blen_m1) begin
          s_nxt.st = QBS_ST_IDLE;
          if (s_r.ap) begin
            s_nxt.open[s_r.bank] = 1'b0;
            fin_ap = 1'b1;
          end
        end else begin
          s_nxt.idx = COL_W'(s_r.idx + 1'b1);
        end
      end

      // A read or write to an open bank, a burst stop or a matching precharge on this edge takes over from the running burst.
      case (cmd)
        QBS_CMD_ACT: begin
          if (s_r.open[bank_select_lines]) begin
            s_nxt.err = 1'b1;
          end
          s_nxt.open[bank_select_lines] = 1'b1;
          s_nxt.row[bank_select_lines] = row_col_addr_lines;
        end
        QBS_CMD_READ, QBS_CMD_WRITE: begin
          if (!s_r.open[bank_select_lines]) begin
            s_nxt.err = 1'b1;
          end else begin
            acc_go = 1'b1;
            acc_rd = (cmd == QBS_CMD_READ);
            acc_bank = bank_select_lines;
            acc_col = row_col_addr_lines[COL_W-1:0];
            fin_ap = 1'b0;
            rd_go = acc_rd;
            wr_go = !acc_rd;
            m1 = blen_of(s_r.bl, !acc_rd && s_r.sw);
            s_nxt.bank = bank_select_lines;
            s_nxt.start = acc_col;
            s_nxt.blen_m1 = m1;
            s_nxt.ap = row_col_addr_lines[QBS_SCOPE_BIT];
            s_nxt.idx = COL_W'(1);
            if (m1 == '0) begin
              s_nxt.st = QBS_ST_IDLE;
              if (row_col_addr_lines[QBS_SCOPE_BIT]) begin
                s_nxt.open[bank_select_lines] = 1'b0;
              end
            end else begin
              s_nxt.st = acc_rd ? QBS_ST_READ : QBS_ST_WRITE;
            end
          end
        end
        QBS_CMD_BSTOP: begin
          s_nxt.st = QBS_ST_IDLE;
          acc_go = 1'b0;
        end
        QBS_CMD_PRE: begin
          // A single-bank precharge leaves other banks their rows and their burst.
          if (row_col_addr_lines[QBS_SCOPE_BIT]) begin
            s_nxt.open = '0;
          end else begin
            s_nxt.open[bank_select_lines] = 1'b0;
          end
          if (row_col_addr_lines[QBS_SCOPE_BIT] || bank_select_lines == s_r.bank) begin
            s_nxt.st = QBS_ST_IDLE;
            acc_go = 1'b0;
          end
        end
        QBS_CMD_REF: begin
          // Refresh needs every bank closed; the count is for software.
          if (|s_r.open || s_r.st != QBS_ST_IDLE) begin
            s_nxt.err = 1'b1;
          end else begin
            s_nxt.refcnt = QBS_REFCNT_W'(s_r.refcnt + 1'b1);
          end
        end
        default: begin
        end
      endcase

      // One array access per edge, read or write.
      if (acc_go && acc_rd) begin
        s_nxt.pipe_v[0] = 1'b1;
        s_nxt.pipe_a[0] = {acc_bank, s_r.row[acc_bank], acc_col};
      end
      if (acc_go && !acc_rd) begin
        wr_en = 1'b1;
        wr_addr = {acc_bank, s_r.row[acc_bank], acc_col};
        wr_lane = ~byte_lane_masks;
      end
    end
    s_nxt.pd = ~cke;

    // APB read data is taken in the setup cycle and held for the access.
    if (psel && !penable) begin
      s_nxt.pslverr = 1'b0;
      stat[QBS_OPEN_LSB +: 4] = s_r.open;
      stat[QBS_RD_BIT] = (s_r.st == QBS_ST_READ);
      stat[QBS_WR_BIT] = (s_r.st == QBS_ST_WRITE);
      stat[QBS_PD_BIT] = s_r.pd;
      stat[QBS_ERR_BIT] = s_r.err;
      case (paddr)
        QBS_MODE_OFS: begin
          s_nxt.prdata = '0;
          s_nxt.prdata[QBS_BL_LSB +: 3] = s_r.bl;
          s_nxt.prdata[QBS_ILV_BIT] = s_r.ilv;
          s_nxt.prdata[QBS_CL3_BIT] = s_r.cl3;
          s_nxt.prdata[QBS_SW_BIT] = s_r.sw;
        end
        QBS_STATUS_OFS: s_nxt.prdata = stat;
        QBS_REFCNT_OFS: s_nxt.prdata = 32'(s_r.refcnt);
        default: begin
          s_nxt.prdata = '0;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
  end

  // All inputs but the asynchronous reset are taken on the rising edge only.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= RST_S;
    end else begin
      s_r <= s_nxt;
    end
  end

  // The slave never inserts wait states.
  assign pready = 1'b1;
  assign prdata = s_r.prdata;
  assign pslverr = s_r.pslverr;
  assign data_bus_lines_out = s_r.dq_q;
  assign data_bus_lines_oe_n = s_r.dq_oe_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Deselected idle core keeps its rows.
  a_cs_ignore: assert property (cs_n && cke && s_r.st == QBS_ST_IDLE |=> $stable(s_r.open))
    else $error("row state changed while deselected");
  a_act_opens: assert property (cke && cmd == QBS_CMD_ACT |=>
      s_r.open[$past(bank_select_lines)] &&
      s_r.row[$past(bank_select_lines)] == $past(row_col_addr_lines))
    else $error("activate did not open the row");
  a_read_cl2: assert property (rd_go && cke && !s_r.cl3 ##1 cke |=> s_r.dq_v)
    else $error("read data late at latency two");
  a_read_cl3: assert property (rd_go && cke && s_r.cl3 ##1 cke [*2] |=> s_r.dq_v)
    else $error("read data late at latency three");
  a_bstop_ends: assert property (cke && cmd == QBS_CMD_BSTOP |=> s_r.st == QBS_ST_IDLE)
    else $error("burst survived a burst stop");
  a_pre_all: assert property (cke && cmd == QBS_CMD_PRE &&
      row_col_addr_lines[QBS_SCOPE_BIT] |=> s_r.open == '0)
    else $error("precharge all left a bank open");
  a_ap_close: assert property (fin_ap && cke |=> !s_r.open[$past(s_r.bank)])
    else $error("auto precharge left the row open");
  a_single_wr: assert property (wr_go && cke && s_r.sw |=> s_r.st == QBS_ST_IDLE)
    else $error("single write ran a burst");
  a_pd_freeze: assert property (!cke |=> $stable(s_r.st) && $stable(s_r.idx))
    else $error("burst moved during power-down");
  a_col_step: assert property (s_r.st == QBS_ST_READ && cke && cmd == QBS_CMD_NOP &&
      s_r.idx != s_r.blen_m1 |=> s_r.idx == COL_W'($past(s_r.idx) + 1'b1))
    else $error("burst column did not advance");

  c_read_cl3: cover property (rd_go && s_r.cl3 ##3 s_r.dq_v);
  c_masked_wr: cover property (wr_go && byte_lane_masks != 4'h0);
  c_bstop_rd: cover property (s_r.st == QBS_ST_READ && cmd == QBS_CMD_BSTOP);
  c_auto_pre: cover property (fin_ap);
endmodule

/* File: dv/qbs_ctrl_model.sv */
// Memory controller model that drives the command pins and captures read words.
`timescale 1ns/1ps
module qbs_ctrl_model (
  // Clock.
  input wire logic clk,
  // Command pins towards the device.
  output logic cke,
  output logic cs_n,
  output logic [2:0] cmd,
  output logic [1:0] ba,
  output logic [10:0] a,
  output logic [3:0] dqm,
  output logic [31:0] dq,
  // Read data from the device.
  input wire logic [31:0] q,
  input wire logic [3:0] q_oe_n
);
  import qbs_pkg::*;
  logic desel;
  logic [31:0] rd_q [8];
  logic [3:0] rd_oe [8];

  // Pins start idle and deselected.
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    desel = 1'b0;
    cmd = QBS_CMD_NOP;
    ba = 2'h0;
    a = 11'h0;
    dqm = 4'h0;
    dq = 32'h0;
  end

  // One command per edge, launched just after an edge so the next edge samples it.
  task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [10:0] ad,
                       input logic [31:0] d, input logic [3:0] m);
    @(posedge clk);
    cs_n <= desel;
    cmd <= c;
    ba <= b;
    a <= ad;
    dq <= d;
    dqm <= m;
  endtask

  // Park the pins on a no-operation; a command left on the pins is taken again each edge.
  task automatic nop();
    issue(QBS_CMD_NOP, 2'h0, 11'h000, 32'h0, 4'h0);
  endtask

  // Read burst; the data lines toggle while unused so stale values never pass.
  task automatic rd(input logic [1:0] b, input logic [10:0] ad, input int cl, input int n);
    issue(QBS_CMD_READ, b, ad, ~dq, 4'h0);
    repeat (cl) issue(QBS_CMD_NOP, b, ad, ~dq, 4'h0);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      rd_q[k] = q;
      rd_oe[k] = q_oe_n;
    end
  endtask

  // Four-word write: word k rides the data lines at the k-th edge after the command.
  task automatic wr4(input logic [1:0] b, input logic [10:0] ad, input logic [31:0] base);
    issue(QBS_CMD_WRITE, b, ad, base, 4'h0);
    for (int k = 1; k < 4; k++) issue(QBS_CMD_NOP, b, ad, base + k, 4'h0);
    issue(QBS_CMD_NOP, b, ad, ~dq, 4'h0);
  endtask
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the quad-bank DRAM core.
`timescale 1ns/1ps
module tb;
  import qbs_pkg::*;
  logic clk, arst_n, cke, cs_n, psel, penable, pwrite, pready, pslverr, e;
  logic [2:0] cmd;
  logic [1:0] ba;
  logic [10:0] a;
  logic [3:0] dqm, oe_n;
  logic [7:0] paddr;
  logic [31:0] dq, q, pwdata, prdata, r;
  logic [31:0] m [8];
  int num_errors, n_compared, cyc;

  qbs_sdram_core dut (.clk(clk), .arst_n(arst_n), .cke(cke), .cs_n(cs_n), .ras_n(cmd[2]),
    .cas_n(cmd[1]), .we_n(cmd[0]), .bank_select_lines(ba), .row_col_addr_lines(a),
    .byte_lane_masks(dqm), .data_bus_lines_in(dq), .data_bus_lines_out(q),
    .data_bus_lines_oe_n(oe_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  qbs_ctrl_model ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .cmd(cmd), .ba(ba), .a(a),
    .dqm(dqm), .dq(dq), .q(q), .q_oe_n(oe_n));

  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic test_done();
    $display("Errors %0d, compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // APB master: request held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(r, exp);
  endtask

  // Read bank 1 and compare against the shadow in the expected column order.
  task automatic burst_chk(input logic [10:0] ad, input int bl, input logic ilv, input int cl);
    int c;
    ctl.rd(2'h1, ad, cl, bl);
    for (int k = 0; k < bl; k++) begin
      c = ilv ? (ad[2:0] ^ k) : ((ad[2:0] & ~(bl - 1)) | ((ad[2:0] + k) & (bl - 1)));
      chk(ctl.rd_q[k], m[c[2:0]]);
      chk({28'h0, ctl.rd_oe[k]}, 32'h0);
    end
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  // Main sequence.
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk({28'h0, oe_n}, 32'hf);
    rdr(QBS_MODE_OFS, 32'h10);
    rdr(8'h0c, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, QBS_MODE_OFS, 32'h0);
    ctl.issue(QBS_CMD_ACT, 2'h1, 11'h005, 32'h0, 4'h0);
    // Single-word writes on back-to-back edges, a new column each cycle.
    for (int k = 0; k < 8; k++) begin
      m[k] = 32'hc0de_0000 + k;
      ctl.issue(QBS_CMD_WRITE, 2'h1, 11'(k), m[k], 4'h0);
    end
    // Burst write, then single-location write mode, both from column 6.
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, QBS_MODE_OFS, j ? 32'h22 : 32'h02);
      ctl.wr4(2'h1, 11'h006, 32'hb000_0000 + 32'(j * 16));
      for (int k = 0; k < 4; k++)
        if (j == 0 || k == 0) m[((6 + k) & 3) | 4] = 32'hb000_0000 + 32'(j * 16 + k);
    end
    apb(1'b1, QBS_MODE_OFS, 32'h0);
    ctl.issue(QBS_CMD_WRITE, 2'h1, 11'h003, 32'hffff_ffff, 4'h5);
    m[3] = (m[3] & 32'h00ff_00ff) | 32'hff00_ff00;
    ctl.desel = 1'b1;
    ctl.issue(QBS_CMD_WRITE, 2'h1, 11'h002, 32'h0, 4'h0);
    ctl.desel = 1'b0;
    // Burst lengths 1 to 8 in both orders, lengths 2 and 8 at latency three, start column 5.
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, QBS_MODE_OFS, {27'h0, i[0], i[2], 1'b0, i[1:0]});
      burst_chk(11'h005, 1 << i[1:0], i[2], 2 + i[0]);
    end
    // Full-page read from column 5: three words checked, the burst keeps running.
    apb(1'b1, QBS_MODE_OFS, 32'h07);
    ctl.rd(2'h1, 11'h005, 2, 3);
    for (int k = 0; k < 3; k++) chk(ctl.rd_q[k], m[5 + k]);
    rdr(QBS_STATUS_OFS, 32'h12);
    // Burst stop one edge after the read: only the first word comes out.
    apb(1'b1, QBS_MODE_OFS, 32'h03);
    ctl.issue(QBS_CMD_READ, 2'h1, 11'h000, 32'h0, 4'h0);
    ctl.issue(QBS_CMD_BSTOP, 2'h1, 11'h000, 32'h0, 4'h0);
    ctl.issue(QBS_CMD_NOP, 2'h1, 11'h000, 32'h0, 4'h0);
    @(posedge clk);
    chk(q, m[0]);
    @(posedge clk);
    chk({28'h0, oe_n}, 32'hf);
    rdr(QBS_STATUS_OFS, 32'h2);
    apb(1'b1, QBS_MODE_OFS, 32'h01);
    ctl.rd(2'h1, 11'h400, 2, 2);
    chk(ctl.rd_q[0], m[0]);
    chk(ctl.rd_q[1], m[1]);
    rdr(QBS_STATUS_OFS, 32'h0);
    ctl.issue(QBS_CMD_ACT, 2'h0, 11'h001, 32'h0, 4'h0);
    ctl.issue(QBS_CMD_ACT, 2'h2, 11'h001, 32'h0, 4'h0);
    ctl.nop();
    rdr(QBS_STATUS_OFS, 32'h5);
    // A second activate of an open bank is a controller fault and sets the sticky error.
    ctl.issue(QBS_CMD_ACT, 2'h2, 11'h001, 32'h0, 4'h0);
    ctl.nop();
    rdr(QBS_STATUS_OFS, 32'h85);
    apb(1'b1, QBS_STATUS_OFS, 32'h80);
    ctl.issue(QBS_CMD_PRE, 2'h0, 11'h000, 32'h0, 4'h0);
    rdr(QBS_STATUS_OFS, 32'h4);
    ctl.issue(QBS_CMD_PRE, 2'h0, 11'h400, 32'h0, 4'h0);
    rdr(QBS_STATUS_OFS, 32'h0);
    ctl.issue(QBS_CMD_REF, 2'h0, 11'h000, 32'h0, 4'h0);
    ctl.nop();
    rdr(QBS_REFCNT_OFS, 32'h1);
    ctl.cke <= 1'b0;
    rdr(QBS_STATUS_OFS, 32'h40);
    ctl.cke <= 1'b1;
    test_done();
  end
endmodule

/* File: shared/qbs_pkg.sv */
// Shared constants and types of the quad-bank synchronous DRAM core.
package qbs_pkg;
  localparam int QBS_BANK_W = 2;
  localparam int QBS_ROW_W = 11;
  localparam int QBS_COL_W = 8;
  localparam int QBS_DATA_W = 32;
  localparam int QBS_LANES = 4;
  localparam int QBS_SCOPE_BIT = 10;
  localparam int QBS_REFCNT_W = 16;
  // Commands as {ras_n, cas_n, we_n}.
  localparam logic [2:0] QBS_CMD_NOP = 3'h7;
  localparam logic [2:0] QBS_CMD_ACT = 3'h3;
  localparam logic [2:0] QBS_CMD_READ = 3'h5;
  localparam logic [2:0] QBS_CMD_WRITE = 3'h4;
  localparam logic [2:0] QBS_CMD_BSTOP = 3'h6;
  localparam logic [2:0] QBS_CMD_PRE = 3'h2;
  localparam logic [2:0] QBS_CMD_REF = 3'h1;
  // Register byte offsets.
  localparam logic [7:0] QBS_MODE_OFS = 8'h00;
  localparam logic [7:0] QBS_STATUS_OFS = 8'h04;
  localparam logic [7:0] QBS_REFCNT_OFS = 8'h08;
  // Mode register fields and reset values.
  localparam int QBS_BL_LSB = 0;
  localparam int QBS_ILV_BIT = 3;
  localparam int QBS_CL3_BIT = 4;
  localparam int QBS_SW_BIT = 5;
  localparam logic [2:0] QBS_BL_RST = 3'h0;
  localparam logic QBS_ILV_RST = 1'b0;
  localparam logic QBS_CL3_RST = 1'b1;
  localparam logic QBS_SW_RST = 1'b0;
  // Burst length codes.
  localparam logic [2:0] QBS_BL_1 = 3'h0;
  localparam logic [2:0] QBS_BL_2 = 3'h1;
  localparam logic [2:0] QBS_BL_4 = 3'h2;
  localparam logic [2:0] QBS_BL_8 = 3'h3;
  localparam logic [2:0] QBS_BL_PAGE = 3'h7;
  // Status register fields.
  localparam int QBS_OPEN_LSB = 0;
  localparam int QBS_RD_BIT = 4;
  localparam int QBS_WR_BIT = 5;
  localparam int QBS_PD_BIT = 6;
  localparam int QBS_ERR_BIT = 7;
  typedef enum logic [2:0] {
    QBS_ST_IDLE = 3'b001,
    QBS_ST_READ = 3'b010,
    QBS_ST_WRITE = 3'b100
  } qbs_burst_t;
endpackage
